// >>> inc/psc_pkg.sv
// psc_pkg: shared constants and carrier types of the power stage control
// and protection block.
// assumes a 40 MHz system clock and a 16-bit serial control frame.
package psc_pkg;

   // stage layout: three half-bridges, stage 2k is low switch k,
   // stage 2k+1 is the high switch of the same bridge
   localparam int NUM_BRIDGES = 3;
   localparam int NUM_STAGES = 2 * NUM_BRIDGES;

   // system clock
   localparam int CLK_PERIOD_NS = 25;

   // protection delays, as printed, and cycle counts derived from them
   localparam int SHUTDOWN_DELAY_NS = 25000;
   localparam int SHUTDOWN_CYCLES = SHUTDOWN_DELAY_NS / CLK_PERIOD_NS;
   localparam int OPEN_LOAD_DELAY_NS = 350000;
   localparam int OPEN_LOAD_CYCLES = OPEN_LOAD_DELAY_NS / CLK_PERIOD_NS;
   localparam int SD_CNT_W = 11;
   localparam int OL_CNT_W = 16;

   // serial frame: width and register addresses
   localparam int FRAME_W = 16;
   localparam logic [1:0] ADDR_ON_BITS = 2'h0;
   localparam logic [1:0] ADDR_CONTROL_REG_ONE = 2'h1;
   localparam logic [1:0] ADDR_CONTROL_REG_THREE = 2'h3;

   // reset values of control and status state
   localparam logic [NUM_STAGES-1:0] STAGE_RESET = 6'h00;
   localparam logic [FRAME_W-1:0] FRAME_RESET = 16'h0000;

   // one control frame as it leaves the shift register
   typedef struct packed {
      logic [1:0] addr;
      logic status_clear_request;
      logic [6:0] unused;
      logic [NUM_STAGES-1:0] data;
   } psc_frame_t;

   // all asynchronous pins that are synchronised in the system domain
   typedef struct packed {
      logic chip_select_n;
      logic direct_pwm_pin_a;
      logic direct_pwm_pin_b;
      logic [NUM_STAGES-1:0] over_current;
      logic [NUM_BRIDGES-1:0] under_current;
   } psc_pins_t;

   localparam int PINS_W = $bits(psc_pins_t);
   localparam logic [PINS_W-1:0] PINS_RESET = 12'h800;

endpackage : psc_pkg

// >>> rtl/psc_link_shift.sv
// psc_link_shift: serial receive shift register on the link clock.
// assumes the master shifts msb first on rising link clock edges while
// chip select is low, and keeps the link clock still between frames.
`timescale 1ns/1ps
module psc_link_shift (
   // link clock and power-on reset
   input wire logic link_clk,
   input wire logic nrst,
   // serial pins
   input wire logic chip_select_n,
   input wire logic serial_in,
   // received frame, stable while chip select is high
   output psc_pkg::psc_frame_t frame
);
   import psc_pkg::*;

   typedef struct packed {
      logic [FRAME_W-1:0] word;
   } psc_link_state_t;

   psc_link_state_t s_reg;
   psc_link_state_t s_next;

   // shift only inside a frame; the word then rests untouched until the
   // next frame, which is what lets the system side read it
   always_comb begin
      s_next = s_reg;
      if (!chip_select_n) begin
         s_next.word = {s_reg.word[FRAME_W-2:0], serial_in};
      end
   end

   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '{word: FRAME_RESET};
      end else begin
         s_reg <= s_next;
      end
   end

   assign frame = psc_frame_t'(s_reg.word);

endmodule : psc_link_shift

// >>> rtl/psc_stage_ctrl.sv
// psc_stage_ctrl: switching and protection of six bridge power stages.
// assumes over/under current comparator outputs arrive as async pins and
// that the serial master keeps a long gap between frames.
//
// Behaviour
// - both selects low: stage follows its on-bit alone, pwm pins ignored.
// - on-bit high and one select high: stage follows that pwm pin.
// - both selects high: on if either pwm high; low on-bit forces off.
// - select bits come from two writable control registers.
// - overcurrent longer than shutdown delay turns switch off, sets overload.
// - after shutdown stage stays off, overload set, until clear or reset.
// - one frame may turn one switch off and the other on together.
// - both switches of a half-bridge requested on is not executed.
// - such a request turns both off and sets both overload bits.
// - open-load detection only on bridge low-side switches.
// - low-side undercurrent past open-load delay sets flag, switch stays on.
// - open-load flags latch until status clear or power-on reset.
// - new control data applies only at chip select rising edge.
// - status clear request executes after the following transmission.
`timescale 1ns/1ps
module psc_stage_ctrl #(
   parameter int OPEN_LOAD_CNT = psc_pkg::OPEN_LOAD_CYCLES
) (
   // system clock and power-on reset
   input wire logic CLK_SYS,
   input wire logic NRST,
   // serial control link
   input wire logic LINK_CLK,
   input wire logic CHIP_SELECT_N,
   input wire logic SERIAL_IN,
   // direct pwm pins
   input wire logic DIRECT_PWM_PIN_A,
   input wire logic DIRECT_PWM_PIN_B,
   // current comparators
   input wire logic [psc_pkg::NUM_STAGES-1:0] OVER_CURRENT,
   input wire logic [psc_pkg::NUM_BRIDGES-1:0] UNDER_CURRENT,
   // stage gates and status
   output logic [psc_pkg::NUM_STAGES-1:0] STAGE_DRIVE,
   output logic [psc_pkg::NUM_STAGES-1:0] OVERLOAD,
   output logic [psc_pkg::NUM_BRIDGES-1:0] OPEN_LOAD_FLAG
);
   import psc_pkg::*;

   typedef struct packed {
      logic [PINS_W-1:0] sync1;
      logic [PINS_W-1:0] sync2;
      logic [PINS_W-1:0] sync3;
      logic [PINS_W-1:0] filt;
      logic [NUM_STAGES-1:0] stage_on_bit;
      logic [NUM_STAGES-1:0] control_reg_one;
      logic [NUM_STAGES-1:0] control_reg_three;
      logic [NUM_STAGES-1:0] drive;
      logic [NUM_STAGES-1:0] ovl;
      logic [NUM_BRIDGES-1:0] open_load_flag;
      logic clr_pend;
      logic [NUM_STAGES-1:0][SD_CNT_W-1:0] sd_cnt;
      logic [NUM_BRIDGES-1:0][OL_CNT_W-1:0] ol_cnt;
   } psc_state_t;

   localparam logic [SD_CNT_W-1:0] SD_LIMIT = SD_CNT_W'(SHUTDOWN_CYCLES);
   localparam logic [OL_CNT_W-1:0] OL_LIMIT = OL_CNT_W'(OPEN_LOAD_CNT);

   psc_state_t s_reg;
   psc_state_t s_next;
   psc_frame_t frame;
   psc_pins_t pins_raw;
   psc_pins_t pins;
   logic apply_now;
   logic clear_now;
   logic [NUM_STAGES-1:0] conflict;
   logic [NUM_STAGES-1:0] pwm_pass;

   // pwm gating of one stage from its two select bits
   function automatic logic pwm_gate(input logic sel_a, input logic sel_b,
                                     input logic pin_a, input logic pin_b);
      if (!sel_a && !sel_b) begin
         pwm_gate = 1'b1;
      end else begin
         pwm_gate = (sel_a & pin_a) | (sel_b & pin_b);
      end
   endfunction : pwm_gate

   // link-clock shift register; its word rests while chip select is high
   psc_link_shift u_link (
      .link_clk(LINK_CLK),
      .nrst(NRST),
      .chip_select_n(CHIP_SELECT_N),
      .serial_in(SERIAL_IN),
      .frame(frame)
   );

   assign pins_raw = '{chip_select_n: CHIP_SELECT_N,
                       direct_pwm_pin_a: DIRECT_PWM_PIN_A,
                       direct_pwm_pin_b: DIRECT_PWM_PIN_B,
                       over_current: OVER_CURRENT,
                       under_current: UNDER_CURRENT};
   assign pins = psc_pins_t'(s_reg.filt);

   // frame end seen once sync stages two and three agree on a high
   // chip select; the frame word is quiet by then, so it is read directly
   assign apply_now = (s_reg.sync2[PINS_W-1] == s_reg.sync3[PINS_W-1]) &&
                      s_reg.sync3[PINS_W-1] && !pins.chip_select_n;
   assign clear_now = apply_now && s_reg.clr_pend;

   // per-bridge conflict and per-stage pwm gating
   for (genvar k = 0; k < NUM_BRIDGES; k++) begin : g_bridge
      assign conflict[2*k] = s_reg.stage_on_bit[2*k] &
                             s_reg.stage_on_bit[2*k+1];
      assign conflict[2*k+1] = conflict[2*k];
   end
   for (genvar i = 0; i < NUM_STAGES; i++) begin : g_stage
      assign pwm_pass[i] = pwm_gate(s_reg.control_reg_one[i],
                                    s_reg.control_reg_three[i],
                                    pins.direct_pwm_pin_a,
                                    pins.direct_pwm_pin_b);
   end

   // next state: sync chain, frame apply, protection counters, latches
   always_comb begin
      logic [NUM_STAGES-1:0] ovl_set;
      logic [NUM_BRIDGES-1:0] opl_set;
      ovl_set = '0;
      opl_set = '0;
      s_next = s_reg;
      // three-stage synchroniser; filtered value moves on agreement
      s_next.sync1 = pins_raw;
      s_next.sync2 = s_reg.sync1;
      s_next.sync3 = s_reg.sync2;
      for (int b = 0; b < PINS_W; b++) begin
         if (s_reg.sync2[b] == s_reg.sync3[b]) begin
            s_next.filt[b] = s_reg.sync3[b];
         end
      end
      // whole frame applied at once, so off/on swaps land together
      if (apply_now) begin
         s_next.clr_pend = frame.status_clear_request;
         unique case (frame.addr)
            ADDR_ON_BITS: s_next.stage_on_bit = frame.data;
            ADDR_CONTROL_REG_ONE: s_next.control_reg_one = frame.data;
            ADDR_CONTROL_REG_THREE: s_next.control_reg_three = frame.data;
            default: ;
         endcase
      end
      // shutdown timers run only while the switch is actually driven
      for (int i = 0; i < NUM_STAGES; i++) begin
         if (s_reg.drive[i] && pins.over_current[i]) begin
            if (s_reg.sd_cnt[i] == SD_LIMIT) begin
               ovl_set[i] = 1'b1;
            end else begin
               s_next.sd_cnt[i] = s_reg.sd_cnt[i] + SD_CNT_W'(1);
            end
         end else begin
            s_next.sd_cnt[i] = '0;
         end
      end
      ovl_set = ovl_set | conflict;
      // open-load timers only on the low switches
      for (int k = 0; k < NUM_BRIDGES; k++) begin
         if (s_reg.drive[2*k] && pins.under_current[k]) begin
            if (s_reg.ol_cnt[k] == OL_LIMIT) begin
               opl_set[k] = 1'b1;
            end else begin
               s_next.ol_cnt[k] = s_reg.ol_cnt[k] + OL_CNT_W'(1);
            end
         end else begin
            s_next.ol_cnt[k] = '0;
         end
      end
      // set wins over a clear arriving in the same cycle
      s_next.ovl = (s_reg.ovl & ~{NUM_STAGES{clear_now}}) | ovl_set;
      s_next.open_load_flag = (s_reg.open_load_flag & ~{NUM_BRIDGES{clear_now}}) | opl_set;
      // open load does not take part here: the switch stays on
      s_next.drive = s_reg.stage_on_bit & pwm_pass & ~s_reg.ovl &
                     ~conflict;
   end

   // async reset: every latch clear and every stage off
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         s_reg <= '{sync1: PINS_RESET, sync2: PINS_RESET,
                    sync3: PINS_RESET, filt: PINS_RESET,
                    stage_on_bit: STAGE_RESET,
                    control_reg_one: STAGE_RESET,
                    control_reg_three: STAGE_RESET,
                    drive: STAGE_RESET, ovl: STAGE_RESET,
                    open_load_flag: 3'h0, clr_pend: 1'b0,
                    sd_cnt: '0, ol_cnt: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign STAGE_DRIVE = s_reg.drive;
   assign OVERLOAD = s_reg.ovl;
   assign OPEN_LOAD_FLAG = s_reg.open_load_flag;

   // checks on the system clock domain
   default clocking cb_sys @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);

   property p_onbit_only;
      (s_reg.control_reg_one == '0 && s_reg.control_reg_three == '0 &&
       s_reg.ovl == '0 && conflict == '0)
      |=> (STAGE_DRIVE == $past(s_reg.stage_on_bit));
   endproperty
   a_onbit_only: assert property (p_onbit_only)
      else $error("stage does not follow on-bit with no select");

   property p_pin_a_low_off;
      (s_reg.control_reg_one[0] && !s_reg.control_reg_three[0] &&
       !pins.direct_pwm_pin_a) |=> !STAGE_DRIVE[0];
   endproperty
   a_pin_a_low_off: assert property (p_pin_a_low_off)
      else $error("stage 0 on while selected pwm pin a low");

   property p_on_low_off;
      1'b1 |=> ((STAGE_DRIVE & ~$past(s_reg.stage_on_bit)) == '0);
   endproperty
   a_on_low_off: assert property (p_on_low_off)
      else $error("stage driven with on-bit low");

   property p_shutdown;
      (s_reg.drive[1] && pins.over_current[1] &&
       s_reg.sd_cnt[1] == SD_LIMIT) |=> OVERLOAD[1] ##1 !STAGE_DRIVE[1];
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("overcurrent past delay did not shut stage 1 down");

   property p_ovl_cause;
      $rose(OVERLOAD[0]) |-> ($past(s_reg.sd_cnt[0]) == SD_LIMIT ||
                              $past(conflict[0]));
   endproperty
   a_ovl_cause: assert property (p_ovl_cause)
      else $error("overload 0 set without cause");

   property p_ovl_hold;
      (!clear_now && OVERLOAD[1]) |=> OVERLOAD[1] ##1 !STAGE_DRIVE[1];
   endproperty
   a_ovl_hold: assert property (p_ovl_hold)
      else $error("overload 1 dropped or stage 1 driven");

   property p_conflict;
      (s_reg.stage_on_bit[1:0] == 2'b11)
      |=> (STAGE_DRIVE[1:0] == 2'b00 && OVERLOAD[1:0] == 2'b11);
   endproperty
   a_conflict: assert property (p_conflict)
      else $error("bridge 0 conflict not refused");

   property p_opl_hold;
      (!clear_now && OPEN_LOAD_FLAG[0]) |=> OPEN_LOAD_FLAG[0];
   endproperty
   a_opl_hold: assert property (p_opl_hold)
      else $error("open-load flag 0 dropped without clear");

   property p_apply_only;
      !apply_now |=> $stable(s_reg.stage_on_bit);
   endproperty
   a_apply_only: assert property (p_apply_only)
      else $error("on-bits changed outside frame end");

   property p_pin_b_follow;
      (s_reg.stage_on_bit[2] && !s_reg.control_reg_one[2] &&
       s_reg.control_reg_three[2] && !s_reg.ovl[2] && !conflict[2])
      |=> (STAGE_DRIVE[2] == $past(pins.direct_pwm_pin_b));
   endproperty
   a_pin_b_follow: assert property (p_pin_b_follow)
      else $error("stage 2 does not follow pwm pin b");

   property p_both_sel;
      (s_reg.stage_on_bit[4] && s_reg.control_reg_one[4] &&
       s_reg.control_reg_three[4] && !s_reg.ovl[4] && !conflict[4])
      |=> (STAGE_DRIVE[4] == $past(pins.direct_pwm_pin_a ||
                                   pins.direct_pwm_pin_b));
   endproperty
   a_both_sel: assert property (p_both_sel)
      else $error("stage 4 does not follow either pwm pin");

   // select bits move only when a frame is applied
   property p_sel_hold;
      !apply_now |=> ($stable(s_reg.control_reg_one) &&
                      $stable(s_reg.control_reg_three));
   endproperty
   a_sel_hold: assert property (p_sel_hold)
      else $error("select bits changed outside frame end");

   property p_frame_load;
      (apply_now && frame.addr == ADDR_ON_BITS)
      |=> (s_reg.stage_on_bit == $past(frame.data));
   endproperty
   a_frame_load: assert property (p_frame_load)
      else $error("on-bit frame not applied as a whole");

   property p_refuse;
      1'b1 |=> ((STAGE_DRIVE & $past(conflict)) == '0);
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("conflicting half-bridge request driven");

   property p_opl_low;
      $rose(OPEN_LOAD_FLAG[0])
      |-> $past(s_reg.drive[0] && pins.under_current[0]);
   endproperty
   a_opl_low: assert property (p_opl_low)
      else $error("open-load 0 set without its low switch driven");

   // open load leaves a plain on-bit stage running
   property p_opl_stay_on;
      (s_reg.drive[0] && pins.under_current[0] &&
       s_reg.ol_cnt[0] == OL_LIMIT && s_reg.stage_on_bit[0] &&
       !s_reg.ovl[0] && !conflict[0] && !s_reg.control_reg_one[0] &&
       !s_reg.control_reg_three[0])
      |=> (OPEN_LOAD_FLAG[0] && STAGE_DRIVE[0]);
   endproperty
   a_opl_stay_on: assert property (p_opl_stay_on)
      else $error("open load did not flag or turned stage 0 off");

   property p_clear_armed;
      $fell(OVERLOAD[1]) |-> $past(clear_now);
   endproperty
   a_clear_armed: assert property (p_clear_armed)
      else $error("overload 1 cleared without an armed clear");

   property p_clear_open;
      (clear_now && !pins.under_current[0]) |=> !OPEN_LOAD_FLAG[0];
   endproperty
   a_clear_open: assert property (p_clear_open)
      else $error("armed clear left open-load flag 0 set");

   // filtered pin moves only to a level both late stages agree on
   property p_sync_agree;
      $changed(pins.direct_pwm_pin_a)
      |-> ($past(s_reg.sync2[PINS_W-2]) == pins.direct_pwm_pin_a &&
           $past(s_reg.sync3[PINS_W-2]) == pins.direct_pwm_pin_a);
   endproperty
   a_sync_agree: assert property (p_sync_agree)
      else $error("pwm pin a passed without sync agreement");

   // this one must run while reset is low, so it overrides the disable
   property p_reset_off;
      @(posedge CLK_SYS) disable iff (1'b0)
      !NRST |=> (STAGE_DRIVE == '0 && OVERLOAD == '0 &&
                 OPEN_LOAD_FLAG == '0);
   endproperty
   a_reset_off: assert property (p_reset_off)
      else $error("stage driven or latch set after reset");

   c_shutdown: cover property ((s_reg.drive[1] && pins.over_current[1])
                               ##1 OVERLOAD[1]);
   c_conflict: cover property (s_reg.stage_on_bit[1:0] == 2'b11);
   c_open_load: cover property ($rose(OPEN_LOAD_FLAG[0]));
   c_clear: cover property (clear_now && OVERLOAD != '0);
   c_pwm_both: cover property (s_reg.control_reg_three[4] &&
                               s_reg.control_reg_one[4] && STAGE_DRIVE[4]);

endmodule : psc_stage_ctrl

// >>> verification/psc_spi_master_model.sv
// psc_spi_master_model: behavioural master of the serial control link.
// assumes the block samples msb first on rising link clock edges.
`timescale 1ns/1ps
module psc_spi_master_model (
   // serial pins
   output logic link_clk,
   output logic chip_select_n,
   output logic serial_in
);
   // idle: clock stands low, select high
   initial begin
      link_clk = 1'b0;
      chip_select_n = 1'b1;
      serial_in = 1'b0;
   end
   // one whole frame at 125 ns per bit, then the quiet gap
   task automatic send(input logic [15:0] word);
      chip_select_n = 1'b0;
      #62.5;
      for (int i = 15; i >= 0; i--) begin
         serial_in = word[i];
         #62.5 link_clk = 1'b1;
         #62.5 link_clk = 1'b0;
      end
      #62.5 chip_select_n = 1'b1;
      serial_in = ~serial_in; // released line must not show the last bit
      #5000;
   endtask : send
endmodule : psc_spi_master_model

// >>> verification/psc_stage_ctrl_test.sv
// psc_stage_ctrl_test: self-checking bench of the stage control block.
// assumes each frame task returns only after the quiet gap has passed.
`timescale 1ns/1ps
module psc_stage_ctrl_test;
   import psc_pkg::*;
   localparam int OL_CNT = 20; // short open-load delay keeps the run brief
   localparam int LIMIT = 30000;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic pwm_a = 1'b0;
   logic pwm_b = 1'b0;
   logic [NUM_STAGES-1:0] over_cur = 6'h00;
   logic [NUM_BRIDGES-1:0] under_cur = 3'h0;
   logic link_clk, cs_n, sdi;
   logic [NUM_STAGES-1:0] drive, ovl;
   logic [NUM_BRIDGES-1:0] olf;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;

   psc_stage_ctrl #(.OPEN_LOAD_CNT(OL_CNT)) dut (
      .CLK_SYS(clk_sys), .NRST(nrst),
      .LINK_CLK(link_clk), .CHIP_SELECT_N(cs_n), .SERIAL_IN(sdi),
      .DIRECT_PWM_PIN_A(pwm_a), .DIRECT_PWM_PIN_B(pwm_b),
      .OVER_CURRENT(over_cur), .UNDER_CURRENT(under_cur),
      .STAGE_DRIVE(drive), .OVERLOAD(ovl), .OPEN_LOAD_FLAG(olf)
   );
   psc_spi_master_model link_master (
      .link_clk(link_clk), .chip_select_n(cs_n), .serial_in(sdi)
   );

   // 40 MHz system clock
   always #12.5 clk_sys = ~clk_sys;

   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [5:0] seen, input logic [5:0] exp,
                        input string msg);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t %s: %h not %h", $time, msg, seen, exp);
      end
   endtask : check

   // inputs move 2 ns after the edge, clear of sampling
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : tick

   task automatic put(input logic [1:0] a, input logic c, input logic [5:0] d);
      link_master.send({a, c, 7'h00, d});
      tick(1);
   endtask : put

   // main sequence
   initial begin
      logic [5:0] exp;
      tick(4);
      nrst = 1'b1;
      tick(1);
      check(drive, 6'h00, "drive at reset");
      check(ovl, 6'h00, "overload at reset");
      check({3'h0, olf}, 6'h00, "open load at reset");
      fork
         put(ADDR_ON_BITS, 1'b0, 6'h15);
         begin
            // fifteen bits in, a decode of the live word would show data
            #1950;
            check(drive, 6'h00, "moved mid frame");
         end
      join
      check(drive, 6'h15, "on bits");
      pwm_a = 1'b1;
      pwm_b = 1'b1;
      tick(6);
      check(drive, 6'h15, "pwm leaked");
      put(ADDR_CONTROL_REG_ONE, 1'b0, 6'h11);
      put(ADDR_CONTROL_REG_THREE, 1'b0, 6'h14);
      // stage 0 on pin a, stage 2 on pin b, stage 4 on either
      // pins step once through four levels, never a fast square wave
      for (int i = 0; i < 4; i++) begin
         {pwm_b, pwm_a} = i[1:0];
         tick(6);
         exp = {1'b0, pwm_a | pwm_b, 1'b0, pwm_b, 1'b0, pwm_a};
         check(drive, exp, "pwm table");
      end
      pwm_b = 1'b0;
      put(ADDR_ON_BITS, 1'b0, 6'h14);
      check(drive, 6'h10, "low on bit");
      put(ADDR_CONTROL_REG_ONE, 1'b0, 6'h00);
      put(ADDR_CONTROL_REG_THREE, 1'b0, 6'h00);
      put(ADDR_ON_BITS, 1'b0, 6'h01);
      put(ADDR_ON_BITS, 1'b0, 6'h02);
      check(drive, 6'h02, "swap");
      check(ovl, 6'h00, "swap flagged");
      put(ADDR_ON_BITS, 1'b0, 6'h03);
      check(drive, 6'h00, "conflict driven");
      check(ovl, 6'h03, "conflict flag");
      put(ADDR_ON_BITS, 1'b1, 6'h00);
      check(ovl, 6'h03, "early clear");
      put(2'h2, 1'b0, 6'h00);
      check(ovl, 6'h00, "no clear");
      // overcurrent on the high switch of bridge 0
      put(ADDR_ON_BITS, 1'b0, 6'h02);
      over_cur = 6'h02;
      tick(SHUTDOWN_CYCLES - 10);
      check(ovl, 6'h00, "early shutdown");
      tick(25);
      check(drive, 6'h00, "no shutdown");
      check(ovl, 6'h02, "no overload");
      over_cur = 6'h00;
      tick(10);
      check(drive, 6'h00, "restarted");
      put(2'h2, 1'b1, 6'h00);
      put(2'h2, 1'b0, 6'h00);
      check(ovl, 6'h00, "overload kept");
      check(drive, 6'h02, "not back on");
      // undercurrent; only the driven low switch may flag
      put(ADDR_ON_BITS, 1'b0, 6'h01);
      under_cur = 3'h7;
      tick(OL_CNT - 5);
      check({3'h0, olf}, 6'h00, "early open load");
      tick(15);
      check({3'h0, olf}, 6'h01, "open load");
      check(drive, 6'h01, "switch dropped");
      under_cur = 3'h0;
      tick(5);
      check({3'h0, olf}, 6'h01, "flag lost");
      put(2'h2, 1'b1, 6'h00);
      put(2'h2, 1'b0, 6'h00);
      check({3'h0, olf}, 6'h00, "flag kept");
      // second reset with latches set
      put(ADDR_ON_BITS, 1'b0, 6'h03);
      nrst = 1'b0;
      tick(2);
      check(ovl, 6'h00, "overload in reset");
      nrst = 1'b1;
      tick(2);
      check(drive, 6'h00, "drive after reset");
      wrap_up();
   end
endmodule : psc_stage_ctrl_test
